// [aos_dac_model.sv]
// behavioural converter pair that records every update
`timescale 1ns/1ps
module aos_dac_model (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire aos_pkg::aos_dac_t dac_code_i,
   input wire logic dac_load_i
);
   import aos_pkg::*;
   aos_dac_t hist [0:63];
   int loads;
   // both channels latch on the same load pulse; history is not reset
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         loads <= 0;
      end else if (dac_load_i) begin
         hist[loads[5:0]] <= dac_code_i;
         loads <= loads + 1;
      end
   end
endmodule : aos_dac_model

// [aos_edge_sync.sv]
// synchroniser and selectable-edge detector for one trigger pin
`timescale 1ns/1ps
module aos_edge_sync (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic pin_i,
   input wire logic fall_i,
   output logic hit_o
);
   logic meta;
   logic sync;
   logic prev;

   // two flops before anything looks at the pin
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= pin_i;
         sync <= meta;
         prev <= sync;
      end
   end

   // only the chosen edge produces a pulse
   assign hit_o = fall_i ? (prev & ~sync) : (sync & ~prev); // [R5]
endmodule : aos_edge_sync

// [aos_pkg.sv]
// shared constants and types of the analog output sequencer
package aos_pkg;
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CMD = 8'h04;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam logic [7:0] REG_COUNT = 8'h0C;
   localparam logic [7:0] REG_DIV = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam logic [7:0] REG_IRQ_STAT = 8'h18;
   localparam logic [7:0] REG_IRQ_CLR = 8'h1C;
   localparam logic [7:0] REG_IRQ_EN = 8'h20;
   localparam logic [7:0] REG_DONE = 8'h24;
   // command bits
   localparam int CMD_START = 0;
   localparam int CMD_STOP = 1;
   localparam int CMD_CLEAR = 2;
   // status fields
   localparam int ST_BUSY = 0;
   localparam int ST_FULL = 1;
   localparam int ST_EMPTY = 2;
   localparam int ST_LEVEL_LSB = 16;
   // start sources
   localparam logic [1:0] SRC_SW = 2'h0;
   localparam logic [1:0] SRC_EXT = 2'h1;
   localparam logic [1:0] SRC_EVT = 2'h2;
   // stop sources
   localparam logic [1:0] STOP_COUNT = 2'h0;
   localparam logic [1:0] STOP_EXT = 2'h1;
   localparam logic [1:0] STOP_EVT = 2'h2;
   localparam logic [1:0] STOP_SW = 2'h3;
   // sampling clock sources
   localparam logic [1:0] CLK_INT = 2'h0;
   localparam logic [1:0] CLK_EXT = 2'h1;
   localparam logic [1:0] CLK_EVT = 2'h2;
   // converter timing: one update takes at most 10 us
   localparam int CLK_PERIOD_PS = 5000;
   localparam int DAC_CONV_NS = 10000;
   localparam int DAC_CONV_CYC = (DAC_CONV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // reset values
   localparam logic [31:0] DIV_RESET = 32'(DAC_CONV_CYC - 1);
   localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
   localparam int BUF_WORDS = 65536;
   localparam int CH_COUNT = 2;
   localparam int CODE_W = 16;
   localparam int EVT_W = 5;
   // control register layout, bit 31 downward
   typedef struct packed {
      logic [21:0] rsvd;
      logic [1:0] clk_src;
      logic clk_fall;
      logic stop_fall;
      logic start_fall;
      logic [1:0] stop_src;
      logic [1:0] start_src;
      logic ring;
   } aos_ctrl_t;
   // interrupt cause layout
   typedef struct packed {
      logic count_done;
      logic overflow;
      logic underrun;
      logic stopped;
      logic started;
   } aos_evt_t;
   // one update: code for each channel
   typedef struct packed {
      logic [CODE_W-1:0] ch1;
      logic [CODE_W-1:0] ch0;
   } aos_dac_t;
   typedef enum {SEQ_IDLE, SEQ_RUN} aos_state_t;
endpackage : aos_pkg

// [aos_sequencer.sv]
// analog output sequencer: sample buffer, trigger control and register slave
//
// Overview of operation
// [R1] two channels, 16-bit code per update
// [R2] 64k-word buffer, FIFO or repeating ring
// [R3] start by software, external pin, event
// [R4] stop by count, pin, event, software
// [R5] each external input acts on chosen edge
// [R6] two status outputs plus sampling clock output
// [R7] errors and events share one interrupt
// [R8] event controller feeds start, stop, clock
// [R9] on stop: no updates, clock off, idle
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module aos_sequencer #(
   parameter int BUF_WORDS = aos_pkg::BUF_WORDS,
   parameter int MIN_PERIOD = aos_pkg::DAC_CONV_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // avalon-mm slave
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // external trigger pins
   input wire logic ext_start_i,
   input wire logic ext_stop_i,
   input wire logic ext_clk_i,
   // event controller pulses, same clock
   input wire logic evt_start_i,
   input wire logic evt_stop_i,
   input wire logic evt_clk_i,
   // converter side
   output aos_pkg::aos_dac_t dac_code_o,
   output logic dac_load_o,
   output logic [1:0] status_o,
   output logic smpl_clk_o,
   output logic irq_o
);
   import aos_pkg::*;

   localparam int FRAMES = BUF_WORDS / CH_COUNT;
   localparam int AW = $clog2(FRAMES);

   aos_ctrl_t ctrl;
   logic [31:0] count_lim;
   logic [31:0] div;
   logic [31:0] div_cnt;
   logic [31:0] done_cnt;
   aos_evt_t irq_stat;
   aos_evt_t irq_en;
   aos_evt_t evt;
   aos_state_t state;
   aos_dac_t mem [FRAMES];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] level;
   logic ack;
   logic wr_ack;
   logic ext_start_hit;
   logic ext_stop_hit;
   logic ext_clk_hit;
   logic start_trig;
   logic stop_trig;
   logic tick;
   logic pop;
   logic push;
   logic clear;
   logic empty;
   logic full;
   logic last_update;
   logic sw_start;
   logic sw_stop;

   // address match on the word part of a byte address
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr[7:2] == off[7:2]);
   endfunction : hit

   // external pins, each with its own edge choice
   aos_edge_sync u_start_sync (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .pin_i(ext_start_i),
      .fall_i(ctrl.start_fall),
      .hit_o(ext_start_hit)
   );
   aos_edge_sync u_stop_sync (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .pin_i(ext_stop_i),
      .fall_i(ctrl.stop_fall),
      .hit_o(ext_stop_hit)
   );
   aos_edge_sync u_clk_sync (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .pin_i(ext_clk_i),
      .fall_i(ctrl.clk_fall),
      .hit_o(ext_clk_hit)
   );

   // bus handshake: answer one cycle after the request is seen
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         avs_waitrequest_o <= 1'b1;
      end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
         avs_waitrequest_o <= 1'b0;
      end else begin
         avs_waitrequest_o <= 1'b1;
      end
   end

   // a request completes at the edge where waitrequest is low
   assign ack = (avs_read_i || avs_write_i) && !avs_waitrequest_o;
   assign wr_ack = ack && avs_write_i;
   assign sw_start = wr_ack && hit(avs_address_i, REG_CMD) && avs_writedata_i[CMD_START];
   assign sw_stop = wr_ack && hit(avs_address_i, REG_CMD) && avs_writedata_i[CMD_STOP];
   assign clear = wr_ack && hit(avs_address_i, REG_CMD) && avs_writedata_i[CMD_CLEAR];
   assign push = wr_ack && hit(avs_address_i, REG_DATA) && !full;

   // read data is latched while waitrequest drops, stands at the answer edge
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (avs_read_i && avs_waitrequest_o) begin
         if (hit(avs_address_i, REG_CTRL)) begin
            avs_readdata_o <= ctrl;
         end else if (hit(avs_address_i, REG_COUNT)) begin
            avs_readdata_o <= count_lim;
         end else if (hit(avs_address_i, REG_DIV)) begin
            avs_readdata_o <= div;
         end else if (hit(avs_address_i, REG_STATUS)) begin
            avs_readdata_o <= 32'h0000_0000;
            avs_readdata_o[ST_BUSY] <= (state == SEQ_RUN);
            avs_readdata_o[ST_FULL] <= full;
            avs_readdata_o[ST_EMPTY] <= empty;
            avs_readdata_o[ST_LEVEL_LSB +: 16] <= 16'(level);
         end else if (hit(avs_address_i, REG_IRQ_STAT)) begin
            avs_readdata_o <= 32'(irq_stat);
         end else if (hit(avs_address_i, REG_IRQ_EN)) begin
            avs_readdata_o <= 32'(irq_en);
         end else if (hit(avs_address_i, REG_DONE)) begin
            avs_readdata_o <= done_cnt;
         end else begin
            // write-only and unmapped offsets read as zero
            avs_readdata_o <= 32'h0000_0000;
         end
      end
   end

   // software configuration registers
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl <= '0;
         count_lim <= COUNT_RESET;
         div <= DIV_RESET;
         irq_en <= '0;
      end else if (wr_ack) begin
         if (hit(avs_address_i, REG_CTRL)) begin
            ctrl <= avs_writedata_i;
            ctrl.rsvd <= '0;
         end else if (hit(avs_address_i, REG_COUNT)) begin
            count_lim <= avs_writedata_i;
         end else if (hit(avs_address_i, REG_DIV)) begin
            div <= avs_writedata_i;
         end else if (hit(avs_address_i, REG_IRQ_EN)) begin
            irq_en <= aos_evt_t'(avs_writedata_i[EVT_W-1:0]);
         end
      end
   end

   // trigger source selection
   always_comb begin
      case (ctrl.start_src) // [R3]
         SRC_SW: start_trig = sw_start;
         SRC_EXT: start_trig = ext_start_hit;
         SRC_EVT: start_trig = evt_start_i; // [R8]
         default: start_trig = 1'b0;
      endcase
   end

   always_comb begin
      case (ctrl.stop_src) // [R4]
         STOP_COUNT: stop_trig = last_update;
         STOP_EXT: stop_trig = ext_stop_hit;
         STOP_EVT: stop_trig = evt_stop_i; // [R8]
         STOP_SW: stop_trig = sw_stop;
         default: stop_trig = 1'b0;
      endcase
   end

   // sampling tick: internal divider, pin or event controller
   always_comb begin
      tick = 1'b0;
      if (state == SEQ_RUN) begin
         case (ctrl.clk_src)
            CLK_INT: tick = (div_cnt == 32'h0000_0000);
            CLK_EXT: tick = ext_clk_hit; // [R5]
            CLK_EVT: tick = evt_clk_i; // [R8]
            default: tick = 1'b0;
         endcase
      end
   end

   assign empty = (level == '0);
   assign full = (level == (AW+1)'(FRAMES));
   assign pop = tick && !empty;
   // the count stop fires on the update that reaches the limit
   assign last_update = pop && (count_lim != 32'h0000_0000) && (done_cnt + 32'h1 >= count_lim);

   // internal divider; period never below the converter settling time
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_cnt <= 32'h0000_0000;
      end else if (state != SEQ_RUN) begin
         div_cnt <= 32'h0000_0000;
      end else if (div_cnt == 32'h0000_0000) begin
         div_cnt <= (div < 32'(MIN_PERIOD - 1)) ? 32'(MIN_PERIOD - 1) : div;
      end else begin
         div_cnt <= div_cnt - 32'h1;
      end
   end

   // run state: idle waits for start, run until stop
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= SEQ_IDLE;
      end else begin
         case (state)
            SEQ_IDLE: begin
               if (start_trig) begin
                  state <= SEQ_RUN; // [R3]
               end
            end
            SEQ_RUN: begin
               if (stop_trig) begin
                  state <= SEQ_IDLE; // [R9]
               end
            end
            default: state <= SEQ_IDLE;
         endcase
      end
   end

   // update counter, restarted by each start
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         done_cnt <= 32'h0000_0000;
      end else if (state == SEQ_IDLE && start_trig) begin
         done_cnt <= 32'h0000_0000;
      end else if (pop) begin
         done_cnt <= done_cnt + 32'h1;
      end
   end

   // sample store, one frame holds both channel codes
   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem[wr_ptr] <= aos_dac_t'(avs_writedata_i); // [R1]
      end
   end

   // buffer pointers: fifo consumes, ring rewinds to the first frame
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end else if (clear) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end else if (ctrl.ring) begin
         // ring keeps its contents and replays them
         if (push) begin
            wr_ptr <= wr_ptr + AW'(1);
            level <= level + (AW+1)'(1);
         end
         if (pop) begin
            rd_ptr <= ((AW+1)'(rd_ptr) + (AW+1)'(1) >= level) ? '0 : rd_ptr + AW'(1); // [R2]
         end
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= rd_ptr + AW'(1); // [R2]
         end
         if (push && !pop) begin
            level <= level + (AW+1)'(1);
         end else if (pop && !push) begin
            level <= level - (AW+1)'(1);
         end
      end
   end

   // converter update: codes and load strobe share one edge
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dac_code_o <= '0;
         dac_load_o <= 1'b0;
      end else begin
         dac_load_o <= pop; // [R9]
         if (pop) begin
            dac_code_o <= mem[rd_ptr]; // [R1]
         end
      end
   end

   // pin outputs: busy, error and the sampling clock
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         status_o <= 2'h0;
         smpl_clk_o <= 1'b0;
      end else begin
         // running flag and clock pulse both trail the run state by one edge
         status_o[0] <= (state == SEQ_RUN); // [R6]
         status_o[1] <= irq_stat.underrun || irq_stat.overflow; // [R6]
         // clock pulses stop as soon as the run ends
         smpl_clk_o <= tick; // [R9]
      end
   end

   // event causes
   always_comb begin
      evt.started = (state == SEQ_IDLE) && start_trig;
      evt.stopped = (state == SEQ_RUN) && stop_trig;
      evt.underrun = tick && empty;
      evt.overflow = wr_ack && hit(avs_address_i, REG_DATA) && full;
      evt.count_done = last_update;
   end

   // sticky causes; a new event wins over a clear in the same cycle
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_stat <= '0;
      end else if (wr_ack && hit(avs_address_i, REG_IRQ_CLR)) begin
         irq_stat <= (irq_stat & ~aos_evt_t'(avs_writedata_i[EVT_W-1:0])) | evt; // [R7]
      end else begin
         irq_stat <= irq_stat | evt; // [R7]
      end
   end

   // one shared level interrupt line
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat & irq_en); // [R7]
      end
   end
endmodule : aos_sequencer

// [aos_sequencer_chk.sv]
// port assertions of the analog output sequencer
`timescale 1ns/1ps
module aos_seq_chk #(
   parameter int BUF_WORDS = 65536,
   parameter int MIN_PERIOD = 2000
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic avs_waitrequest_o,
   input wire aos_pkg::aos_dac_t dac_code_o,
   input wire logic dac_load_o,
   input wire logic [1:0] status_o,
   input wire logic smpl_clk_o,
   input wire logic irq_o
);
   import aos_pkg::*;
   // one domain, so clock and reset are given once
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   load_with_clk_a: assert property (dac_load_o |-> smpl_clk_o)
      else $error("update without sampling clock pulse");
   load_gap_a: assert property (dac_load_o |=> !dac_load_o [*3])
      else $error("updates closer than the shortened period");
   code_hold_a: assert property (!dac_load_o |-> $stable(dac_code_o))
      else $error("codes changed without an update");
   // running flag and clock pulse come from the same run state, same edge
   clk_when_run_a: assert property (smpl_clk_o |-> status_o[0])
      else $error("sampling clock while idle");
   idle_quiet_a: assert property (!status_o[0] [*4] |-> !dac_load_o)
      else $error("update after stop");
   wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low longer than one cycle");
   bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o)
      else $error("request not answered next cycle");
   idle_wait_a: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
      else $error("waitrequest low with no request");
   cover property (dac_load_o);
   cover property ($fell(status_o[0]));
   cover property ($rose(irq_o));
endmodule : aos_seq_chk

bind aos_sequencer aos_seq_chk #(.BUF_WORDS(BUF_WORDS), .MIN_PERIOD(MIN_PERIOD))
   i_aos_seq_chk (.core_clk_i, .rst_b_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o,
   .dac_code_o, .dac_load_o, .status_o, .smpl_clk_o, .irq_o);

// [aos_sequencer_tb.sv]
// self-checking bench of the analog output sequencer
`timescale 1ns/1ps
module aos_sequencer_tb;
   import aos_pkg::*;
   logic clk, rst_b, rd, wr, wreq, ld, sclk, irq;
   logic ext_start, ext_stop, ext_clk, evt_start, evt_stop, evt_clk;
   logic [7:0] addr;
   logic [31:0] wdat, rdat;
   logic [1:0] st;
   aos_dac_t code;
   int errors, num_checks, b, k;
   // small buffer of 8 frames and a 4-cycle period floor keep the run short
   aos_sequencer #(.BUF_WORDS(16), .MIN_PERIOD(4)) i_aos_sequencer (.core_clk_i(clk),
      .rst_b_i(rst_b), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
      .ext_start_i(ext_start), .ext_stop_i(ext_stop), .ext_clk_i(ext_clk),
      .evt_start_i(evt_start), .evt_stop_i(evt_stop), .evt_clk_i(evt_clk),
      .dac_code_o(code), .dac_load_o(ld), .status_o(st), .smpl_clk_o(sclk), .irq_o(irq));
   aos_dac_model i_aos_dac_model (.core_clk_i(clk), .rst_b_i(rst_b), .dac_code_i(code),
      .dac_load_i(ld));
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", s, e, g);
         errors++;
      end
   endtask : chk
   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      // one wait state per access
      chk("bus wait", 32'h2, 32'(n));
   endtask : bus
   task automatic wr32(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr32
   task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(s, e, q);
   endtask : rdc
   function automatic logic [31:0] fr(input int n);
      return {16'hC000 + 16'(n), 16'h3000 + 16'(n)};
   endfunction : fr
   task automatic wait_loads(input int n);
      int t;
      for (t = 0; t < 400 && i_aos_dac_model.loads < n; t++) @(posedge clk);
      chk("loads", 32'(n), 32'(i_aos_dac_model.loads));
   endtask : wait_loads
   task automatic t_reset();
      chk("status_o", 32'h0, 32'(st));
      rdc("div", REG_DIV, DIV_RESET);
      rdc("count", REG_COUNT, COUNT_RESET);
      rdc("status", REG_STATUS, 32'h0000_0004);
      rdc("unmapped", 8'hFC, 32'h0);
   endtask : t_reset
   task automatic t_count();
      wr32(REG_DIV, 32'h0);
      wr32(REG_COUNT, 32'h3);
      for (k = 0; k < 3; k++) wr32(REG_DATA, fr(k));
      wr32(REG_CTRL, 32'h0);
      b = i_aos_dac_model.loads;
      wr32(REG_CMD, 32'h1);
      wait_loads(b + 3);
      for (k = 0; k < 3; k++) chk("fifo code", fr(k), i_aos_dac_model.hist[b + k]);
      repeat (20) @(posedge clk);
      chk("count stop loads", 32'(b + 3), 32'(i_aos_dac_model.loads));
      chk("idle after count", 32'h0, 32'(st[0]));
      rdc("done", REG_DONE, 32'h3);
   endtask : t_count
   task automatic t_ring();
      wr32(REG_CMD, 32'h4);
      wr32(REG_CTRL, 32'h19);
      wr32(REG_DATA, fr(4));
      wr32(REG_DATA, fr(5));
      b = i_aos_dac_model.loads;
      wr32(REG_CMD, 32'h1);
      wait_loads(b + 5);
      wr32(REG_CMD, 32'h2);
      repeat (10) @(posedge clk);
      chk("idle after sw stop", 32'h0, 32'(st[0]));
      for (k = 0; k < 5; k++) chk("ring code", fr(4 + k % 2), i_aos_dac_model.hist[b + k]);
   endtask : t_ring
   // start on falling pin edge, stop and clock on rising pin edges
   task automatic t_ext();
      wr32(REG_CMD, 32'h4);
      wr32(REG_DATA, fr(7));
      wr32(REG_CTRL, 32'h12A);
      b = i_aos_dac_model.loads;
      ext_start <= 1'b1;
      repeat (8) @(posedge clk);
      chk("wrong start edge", 32'h0, 32'(st[0]));
      ext_start <= 1'b0;
      repeat (8) @(posedge clk);
      chk("ext start", 32'h1, 32'(st[0]));
      ext_clk <= 1'b1;
      repeat (8) @(posedge clk);
      ext_clk <= 1'b0;
      repeat (8) @(posedge clk);
      chk("ext clock loads", 32'(b + 1), 32'(i_aos_dac_model.loads));
      chk("ext clock code", fr(7), i_aos_dac_model.hist[b]);
      ext_stop <= 1'b1;
      repeat (8) @(posedge clk);
      chk("ext stop", 32'h0, 32'(st[0]));
      ext_stop <= 1'b0;
   endtask : t_ext
   task automatic t_evt();
      wr32(REG_CTRL, 32'h14);
      evt_start <= 1'b1;
      @(posedge clk);
      evt_start <= 1'b0;
      repeat (16) @(posedge clk);
      chk("evt start", 32'h1, 32'(st[0]));
      chk("underrun status", 32'h1, 32'(st[1]));
      // switch to the event clock first so no internal tick eats the frame
      wr32(REG_CTRL, 32'h214);
      rdc("ctrl", REG_CTRL, 32'h214);
      wr32(REG_DATA, fr(8));
      b = i_aos_dac_model.loads;
      evt_clk <= 1'b1;
      @(posedge clk);
      evt_clk <= 1'b0;
      @(posedge clk);
      chk("evt clock pulse", 32'h1, 32'(sclk));
      chk("evt clock load", 32'h1, 32'(ld));
      repeat (2) @(posedge clk);
      chk("evt clock loads", 32'(b + 1), 32'(i_aos_dac_model.loads));
      chk("evt clock code", fr(8), i_aos_dac_model.hist[b]);
      evt_stop <= 1'b1;
      @(posedge clk);
      evt_stop <= 1'b0;
      repeat (4) @(posedge clk);
      chk("evt stop", 32'h0, 32'(st[0]));
   endtask : t_evt
   task automatic t_irq();
      wr32(REG_IRQ_CLR, 32'h1F);
      wr32(REG_IRQ_EN, 32'h8);
      rdc("irq enable", REG_IRQ_EN, 32'h8);
      wr32(REG_CMD, 32'h4);
      for (k = 0; k < 9; k++) wr32(REG_DATA, fr(k));
      rdc("full status", REG_STATUS, 32'h0008_0002);
      rdc("irq stat", REG_IRQ_STAT, 32'h8);
      chk("irq raised", 32'h1, 32'(irq));
      wr32(REG_IRQ_EN, 32'h0);
      repeat (2) @(posedge clk);
      chk("irq masked", 32'h0, 32'(irq));
      wr32(REG_IRQ_EN, 32'h8);
      wr32(REG_IRQ_CLR, 32'h8);
      repeat (2) @(posedge clk);
      chk("irq cleared", 32'h0, 32'(irq));
      chk("error status", 32'h0, 32'(st[1]));
   endtask : t_irq
   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #100000;
      errors++;
      print_verdict();
   end
   initial begin
      {rst_b, rd, wr, ext_start, ext_stop, ext_clk, evt_start, evt_stop, evt_clk} = 9'h000;
      addr = 8'h00;
      wdat = 32'h0;
      errors = 0;
      num_checks = 0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_count();
      t_ring();
      t_ext();
      t_evt();
      t_irq();
      print_verdict();
   end
endmodule : aos_sequencer_tb
